// *** swb_byte_io.sv ***
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "swb_params.svh"

module swb_byte_io #(
   parameter int SLOT_STD_NS = `SWB_T_SLOT_STD_NS,
   parameter int SLOT_FAST_NS = `SWB_T_SLOT_FAST_NS,
   parameter int W0L_STD_NS = `SWB_T_W0L_STD_NS,
   parameter int W0L_FAST_NS = `SWB_T_W0L_FAST_NS,
   parameter int W1L_STD_NS = `SWB_T_W1L_STD_NS,
   parameter int W1L_FAST_NS = `SWB_T_W1L_FAST_NS,
   parameter int MSR_STD_NS = `SWB_READ_SAMPLE_TIME_STD_NS,
   parameter int MSR_FAST_NS = `SWB_READ_SAMPLE_TIME_FAST_NS,
   parameter int APU_NS = `SWB_T_APU_NS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // Single-wire line, open drain
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_o,
   // Pullup controls and status
   output logic apu_o,
   output logic spu_o,
   output logic line_busy_flag_o
);

   // ****************************************
   // Timing counts
   // ****************************************
   // Every count but the start limit rounds up so no phase ever comes out shorter than asked
   localparam int CLK = `SWB_CLK_NS;
   localparam swb_pkg::swb_cnt_t C_SLOT_STD = 16'((SLOT_STD_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_SLOT_FAST = 16'((SLOT_FAST_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_W0L_STD = 16'((W0L_STD_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_W0L_FAST = 16'((W0L_FAST_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_W1L_STD = 16'((W1L_STD_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_W1L_FAST = 16'((W1L_FAST_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_MSR_STD = 16'((MSR_STD_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_MSR_FAST = 16'((MSR_FAST_NS + CLK - 1) / CLK);
   localparam swb_pkg::swb_cnt_t C_APU = 16'((APU_NS + CLK - 1) / CLK);
   // Longest start delay allowed, rounded down; the engine starts one edge after the accept
   localparam int C_START_MAX = (`SWB_T_START_MAX_PS / 1000) / CLK;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic swb_pkg::swb_reg_e reg_decode(input logic [7:0] adr);
      unique case (adr)
         `SWB_ADDR_CMD: reg_decode = swb_pkg::SWB_R_CMD;
         `SWB_ADDR_CFG: reg_decode = swb_pkg::SWB_R_CFG;
         `SWB_ADDR_STAT: reg_decode = swb_pkg::SWB_R_STAT;
         `SWB_ADDR_RDATA: reg_decode = swb_pkg::SWB_R_RDATA;
         `SWB_ADDR_RPTR: reg_decode = swb_pkg::SWB_R_RPTR;
         `SWB_ADDR_PORT: reg_decode = swb_pkg::SWB_R_PORT;
         default: reg_decode = swb_pkg::SWB_R_NONE;
      endcase
   endfunction

   function automatic logic [31:0] stat_word(input swb_pkg::swb_state_s s);
      stat_word = 32'h0000_0000;
      stat_word[`SWB_STAT_BUSY_BIT] = s.busy;
      stat_word[`SWB_STAT_REFUSED_BIT] = s.refused;
      stat_word[`SWB_STAT_RPTR_BIT] = s.rptr;
   endfunction

   swb_pkg::swb_state_s q;
   swb_pkg::swb_state_s n;

   // Slot figures for the speed latched at command start
   swb_pkg::swb_cnt_t slot_len;
   swb_pkg::swb_cnt_t low_len;
   swb_pkg::swb_cnt_t samp_at;
   swb_pkg::swb_cnt_t cnt_nx;
   swb_pkg::swb_reg_e sel_reg;
   logic [7:0] op;
   logic start_ok;

   assign slot_len = q.speed_lat ? C_SLOT_FAST : C_SLOT_STD;
   assign samp_at = q.speed_lat ? C_MSR_FAST : C_MSR_STD;
   // A one bit gives the short low pulse, a zero bit the long one
   assign low_len = q.shreg[0] ? (q.speed_lat ? C_W1L_FAST : C_W1L_STD)
                               : (q.speed_lat ? C_W0L_FAST : C_W0L_STD); // see RL16
   assign cnt_nx = q.cnt + 16'h0001;
   assign sel_reg = reg_decode(wb_adr_i);
   assign op = wb_dat_i[7:0];
   assign start_ok = C_START_MAX >= 1;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      n = q;
      n.ack = 1'b0;
      n.line_out = 1'b0;

      // Three-stage synchroniser; a new level counts once stages two and three agree
      n.sync = {q.sync[1:0], line_i};
      if (q.sync[2] == q.sync[1]) begin
         n.line_lvl = q.sync[2];
      end

      // Slot engine
      unique case (q.st)
         swb_pkg::SWB_IDLE: begin
            n.line_oe = 1'b0;
            n.active_pullup_enable = 1'b0;
         end
         swb_pkg::SWB_SLOT: begin
            if (q.cnt == samp_at) begin
               n.samp = q.line_lvl; // see RL16
            end
            if (q.cnt == slot_len - 16'h0001) begin
               // Shift right: the next line bit is bit 0, the sample enters at the top
               n.shreg = {(q.cnt == samp_at) ? q.line_lvl : q.samp, q.shreg[7:1]}; // see RL2
               n.cnt = 16'h0000;
               n.bitn = q.bitn + 3'h1;
               if (q.bitn == 3'h7) begin
                  // Busy drops right after the eighth slot
                  n.st = swb_pkg::SWB_IDLE; // see RL5
                  n.line_oe = 1'b0;
                  n.active_pullup_enable = 1'b0;
                  n.strong_pullup_enable = q.spu_arm; // see RL10
                  if (q.is_read) begin
                     // First sample has reached bit 0 after eight shifts
                     n.rdata = {(q.cnt == samp_at) ? q.line_lvl : q.samp, q.shreg[7:1]}; // see RL12 RL17
                  end
               end else begin
                  n.line_oe = 1'b1;
                  n.active_pullup_enable = 1'b0;
               end
            end else begin
               n.cnt = cnt_nx;
               n.line_oe = cnt_nx < low_len;
               // Active pullup only in the short window after the release
               n.active_pullup_enable = q.apu_lat && (cnt_nx >= low_len) && (cnt_nx < low_len + C_APU); // see RL10 RL11
            end
         end
      endcase

      // Wishbone slave: one wait state, ack for one cycle
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         n.ack = 1'b1;
         n.dat = 32'h0000_0000;
         if (wb_we_i) begin
            unique case (sel_reg)
               swb_pkg::SWB_R_CMD: begin
                  if (wb_sel_i[0] && (op == `SWB_OP_WRITE_BYTE || op == `SWB_OP_READ_BYTE)) begin
                     if (q.busy || q.st != swb_pkg::SWB_IDLE) begin
                        // Refused command leaves the engine untouched
                        n.refused = 1'b1; // see RL6 RL7
                     end else if (op == `SWB_OP_WRITE_BYTE && !wb_sel_i[1]) begin
                        // A write without its data lane is discarded
                        n.refused = 1'b1; // see RL6
                     end else if (start_ok) begin
                        n.refused = 1'b0;
                        n.rptr = `SWB_RPTR_STATUS; // see RL9
                        n.is_read = (op == `SWB_OP_READ_BYTE);
                        // A read sends all ones so every slot is a sampled write-one slot
                        n.shreg = (op == `SWB_OP_READ_BYTE) ? 8'hFF
                                  : wb_dat_i[`SWB_CMD_DATA_LSB +: 8]; // see RL1 RL12 RL13
                        n.speed_lat = q.cfg.speed; // see RL10 RL11
                        n.apu_lat = q.cfg.apu_en; // see RL10 RL11
                        n.spu_arm = (op == `SWB_OP_WRITE_BYTE) && q.cfg.spu_en; // see RL10 RL11
                        n.strong_pullup_enable = 1'b0;
                        n.samp = 1'b1;
                        n.cnt = 16'h0000;
                        n.bitn = 3'h0;
                        // Line goes low on the very next edge
                        n.st = swb_pkg::SWB_SLOT; // see RL3 RL4 RL14
                        n.line_oe = 1'b1;
                        n.active_pullup_enable = 1'b0;
                     end
                  end
               end
               swb_pkg::SWB_R_CFG: begin
                  if (wb_sel_i[0]) begin
                     n.cfg.speed = wb_dat_i[`SWB_CFG_SPEED_BIT];
                     n.cfg.spu_en = wb_dat_i[`SWB_CFG_SPU_BIT];
                     n.cfg.apu_en = wb_dat_i[`SWB_CFG_APU_BIT];
                     // Clearing the enable also ends a strong pullup in progress; a write ending now still wins
                     if (!wb_dat_i[`SWB_CFG_SPU_BIT] &&
                         !(q.st == swb_pkg::SWB_SLOT && n.st == swb_pkg::SWB_IDLE)) begin
                        n.strong_pullup_enable = 1'b0;
                     end
                  end
               end
               swb_pkg::SWB_R_RPTR: begin
                  if (wb_sel_i[0]) begin
                     n.rptr = wb_dat_i[0];
                  end
               end
               default: begin
               end
            endcase
         end else begin
            unique case (sel_reg)
               swb_pkg::SWB_R_CFG: begin
                  n.dat[`SWB_CFG_SPEED_BIT] = q.cfg.speed;
                  n.dat[`SWB_CFG_SPU_BIT] = q.cfg.spu_en;
                  n.dat[`SWB_CFG_APU_BIT] = q.cfg.apu_en;
               end
               swb_pkg::SWB_R_STAT: n.dat = stat_word(q);
               swb_pkg::SWB_R_RDATA: n.dat = {24'h00_0000, q.rdata};
               swb_pkg::SWB_R_RPTR: n.dat = {31'h0000_0000, q.rptr};
               swb_pkg::SWB_R_PORT: begin
                  // Host-style read through the pointer
                  n.dat = (q.rptr == `SWB_RPTR_RDATA) ? {24'h00_0000, q.rdata} : stat_word(q); // see RL15
               end
               default: n.dat = 32'h0000_0000;
            endcase
         end
      end

      n.busy = (n.st == swb_pkg::SWB_SLOT); // see RL5
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q.st <= swb_pkg::SWB_IDLE;
         q.cnt <= 16'h0000;
         q.bitn <= 3'h0;
         q.shreg <= 8'h00;
         q.samp <= 1'b1;
         q.is_read <= 1'b0;
         q.speed_lat <= 1'b0;
         q.apu_lat <= 1'b0;
         q.spu_arm <= 1'b0;
         q.cfg <= `SWB_CFG_RESET;
         q.rdata <= 8'h00;
         q.refused <= 1'b0;
         q.rptr <= `SWB_RPTR_STATUS;
         q.ack <= 1'b0;
         q.dat <= 32'h0000_0000;
         q.line_out <= 1'b0;
         q.line_oe <= 1'b0;
         q.active_pullup_enable <= 1'b0;
         q.strong_pullup_enable <= 1'b0;
         q.busy <= 1'b0;
         q.sync <= 3'h7;
         q.line_lvl <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign line_o = q.line_out;
   assign line_oe_o = q.line_oe;
   assign apu_o = q.active_pullup_enable;
   assign spu_o = q.strong_pullup_enable;
   assign line_busy_flag_o = q.busy;

endmodule

// *** swb_params.svh ***
`ifndef SWB_PARAMS_SVH
`define SWB_PARAMS_SVH
// Function
// RL1: A write-byte command with its data byte drives that byte onto the line as eight bit slots.
// RL2: The written byte goes out least significant bit first, so the line only starts once the whole byte is in.
// RL3: Line activity of a byte write starts no later than 262.5 ns after the data byte has been received.
// RL4: A byte write finishes within eight slot times plus at most 262.5 ns from the data byte's arrival.
// RL5: During a byte write or byte read the line-busy flag stays one for eight slot times.
// RL6: A write-byte command arriving while the line is busy is refused and discarded along with its data.
// RL7: A read-byte command arriving while the line is busy is refused and ignored.
// RL8: The host only issues a byte command once all earlier line activity has finished.
// RL9: Accepting a byte command points the read pointer at the status register.
// RL10: A byte write uses the speed select, strong pullup enable and active pullup enable settings.
// RL11: A byte read uses only speed select and active pullup enable; the strong pullup is not applied.
// RL12: A read-byte command has no parameter, makes eight read slots and stores the byte in read data.
// RL13: Each read slot is a write-one slot whose line level is sampled.
// RL14: A byte read starts within 262.5 ns of the command and ends within eight slot times plus 262.5 ns.
// RL15: The host gets the byte by pointing the read pointer at read data and then reading.
// RL16: A zero bit makes a write-zero slot, a one bit a write-one slot, both sampled at the sample time.
// RL17: The bit sampled in the first slot of a byte read lands in bit 0 of read data.

// ****************************************
// Register byte addresses
// ****************************************
`define SWB_ADDR_CMD 8'h00
`define SWB_ADDR_CFG 8'h04
`define SWB_ADDR_STAT 8'h08
`define SWB_ADDR_RDATA 8'h0C
`define SWB_ADDR_RPTR 8'h10
`define SWB_ADDR_PORT 8'h14

// ****************************************
// Command codes and field positions
// ****************************************
`define SWB_OP_WRITE_BYTE 8'hA5
`define SWB_OP_READ_BYTE 8'h96
`define SWB_CMD_DATA_LSB 8
`define SWB_CFG_SPEED_BIT 0
`define SWB_CFG_SPU_BIT 1
`define SWB_CFG_APU_BIT 2
`define SWB_STAT_BUSY_BIT 0
`define SWB_STAT_REFUSED_BIT 1
`define SWB_STAT_RPTR_BIT 2
`define SWB_CFG_RESET 3'h0
`define SWB_RPTR_STATUS 1'b0
`define SWB_RPTR_RDATA 1'b1

// ****************************************
// Timing, in ns unless named otherwise
// ****************************************
`define SWB_CLK_NS 20
`define SWB_T_START_MAX_PS 262500
`define SWB_T_SLOT_STD_NS 70000
`define SWB_T_SLOT_FAST_NS 10000
`define SWB_T_W0L_STD_NS 60000
`define SWB_T_W0L_FAST_NS 7500
`define SWB_T_W1L_STD_NS 6000
`define SWB_T_W1L_FAST_NS 1000
`define SWB_READ_SAMPLE_TIME_STD_NS 15000
`define SWB_READ_SAMPLE_TIME_FAST_NS 2000
`define SWB_T_APU_NS 2500
`endif

// *** swb_pkg.sv ***
package swb_pkg;

   // Slot engine states, one-hot
   typedef enum logic [1:0] {
      SWB_IDLE = 2'b01,
      SWB_SLOT = 2'b10
   } swb_state_e;

   // Register decode result
   typedef enum logic [2:0] {
      SWB_R_CMD,
      SWB_R_CFG,
      SWB_R_STAT,
      SWB_R_RDATA,
      SWB_R_RPTR,
      SWB_R_PORT,
      SWB_R_NONE
   } swb_reg_e;

   typedef struct packed {
      logic apu_en;
      logic spu_en;
      logic speed;
   } swb_cfg_s;

   typedef logic [15:0] swb_cnt_t;

   typedef struct packed {
      swb_state_e st;
      swb_cnt_t cnt;
      logic [2:0] bitn;
      logic [7:0] shreg;
      logic samp;
      logic is_read;
      logic speed_lat;
      logic apu_lat;
      logic spu_arm;
      swb_cfg_s cfg;
      logic [7:0] rdata;
      logic refused;
      logic rptr;
      logic ack;
      logic [31:0] dat;
      logic line_out;
      logic line_oe;
      logic active_pullup_enable;
      logic strong_pullup_enable;
      logic busy;
      logic [2:0] sync;
      logic line_lvl;
   } swb_state_s;

endpackage

// *** swb_byte_io_properties.sv ***
`timescale 1ns/10ps
module swb_byte_io_properties #(
   parameter int SLOT_STD_NS = 70000,
   parameter int SLOT_FAST_NS = 10000,
   parameter int W0L_STD_NS = 60000,
   parameter int W0L_FAST_NS = 7500,
   parameter int W1L_STD_NS = 6000,
   parameter int W1L_FAST_NS = 1000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Line and status
   input wire logic line_i,
   input wire logic line_o,
   input wire logic line_oe_o,
   input wire logic apu_o,
   input wire logic spu_o,
   input wire logic line_busy_flag_o
);
   // ****
   // Shadow of settings, busy and low-pulse lengths
   // ****
   logic spd_q, spu_q, apu_q, rd_q;
   logic [15:0] bc_q, oc_q;
   int sl, w1, w0;
   wire cw = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   always_comb begin
      sl = ((spd_q ? SLOT_FAST_NS : SLOT_STD_NS) + 19) / 20;
      w1 = ((spd_q ? W1L_FAST_NS : W1L_STD_NS) + 19) / 20;
      w0 = ((spd_q ? W0L_FAST_NS : W0L_STD_NS) + 19) / 20;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {spd_q, spu_q, apu_q, rd_q} <= 4'h0;
         bc_q <= 16'h0000;
         oc_q <= 16'h0000;
      end else begin
         bc_q <= line_busy_flag_o ? bc_q + 16'h0001 : 16'h0000;
         oc_q <= line_oe_o ? oc_q + 16'h0001 : 16'h0000;
         if (cw && wb_adr_i == 8'h04) begin
            {apu_q, spu_q, spd_q} <= wb_dat_i[2:0];
         end
         if (cw && wb_adr_i == 8'h00 && !line_busy_flag_o) begin
            rd_q <= wb_dat_i[7:0] == 8'h96;
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence acc_s;
      cw && wb_adr_i == 8'h00 && !line_busy_flag_o &&
         (wb_dat_i[7:0] == 8'h96 || (wb_dat_i[7:0] == 8'hA5 && wb_sel_i[1]));
   endsequence
   sequence rel_s;
      $fell(line_oe_o) && apu_q;
   endsequence
   start_now_a: assert property (acc_s |=> line_busy_flag_o && line_oe_o)
      else $error("byte command did not start the line");
   busy_len_a: assert property ($fell(line_busy_flag_o) |-> int'(bc_q) == 8 * sl)
      else $error("busy length differs from eight slots");
   slot_grid_a: assert property ($rose(line_oe_o) |-> int'(bc_q) % sl == 0)
      else $error("slot started off the slot grid");
   low_pulse_a: assert property ($fell(line_oe_o) |-> int'(oc_q) == w1 || (!rd_q && int'(oc_q) == w0))
      else $error("low pulse length wrong");
   spu_write_a: assert property ($fell(line_busy_flag_o) && !rd_q && spu_q |-> ##[0:2] spu_o)
      else $error("strong pullup missing after write");
   spu_cause_a: assert property ($rose(spu_o) |-> spu_q && !rd_q)
      else $error("strong pullup without cause");
   spu_read_a: assert property (line_busy_flag_o && $past(line_busy_flag_o) && rd_q |-> !spu_o)
      else $error("strong pullup during read");
   apu_rel_a: assert property (rel_s |-> ##[0:1] apu_o)
      else $error("active pullup missing");
   apu_cause_a: assert property (apu_o |-> apu_q)
      else $error("active pullup while disabled");
   oe_busy_a: assert property (line_oe_o |-> line_busy_flag_o)
      else $error("line driven while not busy");
   line_low_a: assert property (line_o == 1'b0)
      else $error("open-drain data output not low");
endmodule
bind swb_byte_io swb_byte_io_properties #(
   .SLOT_STD_NS(SLOT_STD_NS), .SLOT_FAST_NS(SLOT_FAST_NS), .W0L_STD_NS(W0L_STD_NS),
   .W0L_FAST_NS(W0L_FAST_NS), .W1L_STD_NS(W1L_STD_NS), .W1L_FAST_NS(W1L_FAST_NS)
) u_swb_byte_io_properties (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_ack_o, .wb_dat_o, .line_i, .line_o, .line_oe_o, .apu_o, .spu_o, .line_busy_flag_o);

// *** swb_slave.sv ***
`timescale 1ns/10ps
module swb_slave (
   // Clock and line
   input wire logic clk_i,
   input wire logic line_oe_i,
   input wire logic line_i,
   // Answer byte and sample point
   input wire logic [7:0] tx_i,
   input wire logic [7:0] hold_i,
   // Pulldown and received byte
   output logic pull_o,
   output logic [7:0] rx_o,
   output logic byte_o
);
   logic oe_q = 1'b0;
   logic [7:0] cnt = 8'h00;
   logic [2:0] k = 3'h0;
   initial begin
      pull_o = 1'b0;
      rx_o = 8'h00;
      byte_o = 1'b0;
   end
   // A zero is answered by holding the line low past the master's sample point
   always @(posedge clk_i) begin
      oe_q <= line_oe_i;
      byte_o <= 1'b0;
      if (line_oe_i && !oe_q) begin
         cnt <= 8'h01;
         pull_o <= !tx_i[k];
      end else if (cnt == hold_i) begin
         cnt <= 8'h00;
         pull_o <= 1'b0;
         rx_o <= {line_i, rx_o[7:1]};
         k <= k + 3'h1;
         byte_o <= k == 3'h7;
      end else if (cnt != 8'h00) begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic wb_ack_o, line_o, line_oe_o, apu_o, spu_o, line_busy_flag_o, pull, byte_done;
   logic [31:0] wb_dat_o, d, t;
   logic [31:0] seed = 32'h0000_0031;
   logic [7:0] tx = 8'hFF;
   logic [7:0] rx;
   logic [7:0] hold = 8'h0A;
   logic [31:0] eq[$], mq[$];
   logic [7:0] lq[$];
   int fail_count = 0;
   int checks_done = 0;
   int cyc_n = 0;
   // Open-drain line with pull-up
   wire line_i = !(line_oe_o || pull);
   always #10 clk_i = ~clk_i;
   // Standard speed and the active pullup time are shrunk for run time, fast speed keeps its own slot figures;
   // the sample point must trail the short low pulse by more than the synchroniser delay
   swb_byte_io #(.SLOT_STD_NS(400), .W0L_STD_NS(300), .W1L_STD_NS(60), .MSR_STD_NS(200),
      .APU_NS(40)) u_swb_byte_io (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
      .wb_dat_o, .line_i, .line_o, .line_oe_o, .apu_o, .spu_o, .line_busy_flag_o);
   swb_slave u_swb_slave (.clk_i, .line_oe_i(line_oe_o), .line_i, .tx_i(tx), .hold_i(hold),
      .pull_o(pull), .rx_o(rx), .byte_o(byte_done));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= v;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      eq.push_back(e);
      mq.push_back(m);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic idle();
      while (line_busy_flag_o !== 1'b0) @(posedge clk_i);
      @(posedge clk_i);
   endtask
   // Results are matched in order against the notes left by the drivers
   always @(posedge clk_i) begin
      cyc_n++;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o & mq.pop_front(), eq.pop_front());
      if (byte_done === 1'b1) chk({24'h00_0000, rx}, {24'h00_0000, lq.pop_front()});
      if (cyc_n == 20000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h04, 32'h0000_0000, 32'h0000_0007);
      rd(8'h08, 32'h0000_0000, 32'h0000_0007);
      rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
      for (int s = 0; s < 2; s++) begin
         hold <= s ? 8'hC8 : 8'h0A;
         wb(1'b1, 8'h04, 32'h0000_0006 | s);
         d = xs();
         tx <= 8'hFF;
         lq.push_back(d[7:0]);
         wb(1'b1, 8'h10, 32'h0000_0001);
         wb(1'b1, 8'h00, {16'h0000, d[7:0], 8'hA5});
         rd(8'h14, 32'h0000_0001, 32'h0000_0007);
         wb(1'b1, 8'h00, {16'h0000, ~d[7:0], 8'hA5});
         rd(8'h08, 32'h0000_0003, 32'h0000_0007);
         idle();
         chk({31'h0000_0000, spu_o}, 32'h0000_0001);
         t = xs();
         tx <= t[7:0];
         lq.push_back(t[7:0]);
         wb(1'b1, 8'h10, 32'h0000_0001);
         wb(1'b1, 8'h00, 32'h0000_0096);
         wb(1'b1, 8'h00, 32'h0000_0096);
         rd(8'h14, 32'h0000_0003, 32'h0000_0007);
         chk({31'h0000_0000, spu_o}, 32'h0000_0000);
         idle();
         chk({31'h0000_0000, line_o}, 32'h0000_0000);
         wb(1'b1, 8'h10, 32'h0000_0001);
         rd(8'h14, {24'h00_0000, t[7:0]}, 32'h0000_00FF);
         rd(8'h0C, {24'h00_0000, t[7:0]}, 32'h0000_00FF);
         rd(8'h08, 32'h0000_0006, 32'h0000_0007);
      end
      summarize();
   end
endmodule
